// *** rtl/upio_pin_cell.sv ***
// One pin cell: mux between serial function and general purpose I/O
// Assumes synchronous pin input; output enable high while driving
`timescale 1ns/1ps
`default_nettype none
module upio_pin_cell (
    input wire logic clk,
    input wire logic reset,
    input wire logic gpioSel,
    input wire logic dirOut,
    input wire logic outLevel,
    input wire logic openDrain,
    input wire logic funcOut,
    input wire logic funcOe,
    input wire logic padIn,
    output logic padOut,
    output logic padOe,
    output logic pinLevel
);
    // Registered drive so every top output comes from a flop
    always_ff @(posedge clk) begin
        if (reset) begin
            padOut <= 1'b0;
            padOe <= 1'b0;
        end else if (gpioSel) begin
            // Open drain only pulls low, releases for a one
            padOut <= openDrain ? 1'b0 : outLevel;
            padOe <= dirOut & ~(openDrain & outLevel);
        end else begin
            padOut <= funcOut;
            padOe <= funcOe;
        end
    end
    // Pin level sampled each cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            pinLevel <= 1'b0;
        end else begin
            pinLevel <= padIn;
        end
    end
endmodule
`default_nettype wire

// *** rtl/upio_pin_ctrl.sv ***
// Pin I/O controller for the three serial port pins, AHB-Lite slave
// Assumes one clock, synchronous reset, single word transfers only
//
// Contract
// - Status bit 16 shows clock pin under I/O
// - Status bit 17 shows transmit pin under I/O
// - Status bit 18 shows receive pin under I/O
// - Direction status: one means output, bits 16-18
// - Output level status returns programmed levels
// - Pin level status shows sampled pin levels
// - Open drain status shows ones for open drain
// - Zero open drain bit means normal drive
// - Decode pin select enable and disable
// - Decode output enable and disable
// - Decode output level set and clear
// - Decode open drain enable and disable
// - Each pin shared, chosen by this controller
// - Soft reset restores all pin registers
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "upio_regs.svh"
module upio_pin_ctrl import upio_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire upio_func_t funcIn,
    output upio_pins_t funcRxd,
    input wire upio_pins_t padIn,
    output upio_pins_t padOut,
    output upio_pins_t padOe,
    output logic portSoftReset
);
    ////////////////////////////////////////////////////////////////////////
    // Pin state registers
    upio_pins_t pinSel_r; // Pin under general purpose control
    upio_pins_t dirOut_r; // Direction, one is output
    upio_pins_t outLevel_r; // Programmed output level
    upio_pins_t openDrain_r; // Open drain selection
    upio_pins_t pinLevel; // Sampled pin levels
    upio_state_t state_r; // Bus phase
    logic [`UPIO_ADDR_MSB:0] addr_r; // Latched address
    logic write_r; // Latched direction
    logic softRst_r; // Soft reset pulse from control word
    logic [2:0] wrBits; // Write data field for the three pins
    logic wrStrobe; // Data phase of a write
    logic addrTake; // Address phase accepted

    ////////////////////////////////////////////////////////////////////////
    // Bus front end
    assign addrTake = hsel & hready & htrans[1];
    assign wrStrobe = (state_r == UPIO_DATA) & write_r;
    assign wrBits = hwdata[`UPIO_FIELD_LSB +: 3];

    // Phase tracker; slave never stretches, so one data cycle per transfer
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= UPIO_IDLE;
            addr_r <= '0;
            write_r <= 1'b0;
        end else begin
            case (state_r)
                UPIO_IDLE: begin
                    if (addrTake) begin
                        state_r <= UPIO_DATA;
                    end
                end
                UPIO_DATA: begin
                    if (!addrTake) begin
                        state_r <= UPIO_IDLE;
                    end
                end
                default: begin
                    state_r <= UPIO_IDLE;
                end
            endcase
            if (addrTake) begin
                addr_r <= haddr[`UPIO_ADDR_MSB:0];
                write_r <= hwrite;
            end
        end
    end

    // Always ready, always OKAY
    always_ff @(posedge clk) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Soft reset: control word bit, one-cycle pulse, restores pin registers to reset values
    always_ff @(posedge clk) begin
        if (reset) begin
            softRst_r <= 1'b0;
        end else begin
            softRst_r <= wrStrobe && addr_r == `UPIO_CTRL && hwdata[`UPIO_SOFT_RST_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            portSoftReset <= 1'b0;
        end else begin
            portSoftReset <= softRst_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Set and clear pairs; writing zero leaves a bit alone
    always_ff @(posedge clk) begin
        if (reset || softRst_r) begin
            pinSel_r <= `UPIO_PSEL_RESET;
        end else if (wrStrobe && addr_r == `UPIO_PSEL_EN) begin
            pinSel_r <= pinSel_r | wrBits;
        end else if (wrStrobe && addr_r == `UPIO_PSEL_DIS) begin
            pinSel_r <= pinSel_r & ~wrBits;
        end
    end
    always_ff @(posedge clk) begin
        if (reset || softRst_r) begin
            dirOut_r <= `UPIO_ZERO_RESET;
        end else if (wrStrobe && addr_r == `UPIO_OUT_EN) begin
            dirOut_r <= dirOut_r | wrBits;
        end else if (wrStrobe && addr_r == `UPIO_OUT_DIS) begin
            dirOut_r <= dirOut_r & ~wrBits;
        end
    end
    always_ff @(posedge clk) begin
        if (reset || softRst_r) begin
            outLevel_r <= `UPIO_ZERO_RESET;
        end else if (wrStrobe && addr_r == `UPIO_LVL_SET) begin
            outLevel_r <= outLevel_r | wrBits;
        end else if (wrStrobe && addr_r == `UPIO_LVL_CLR) begin
            outLevel_r <= outLevel_r & ~wrBits;
        end
    end
    always_ff @(posedge clk) begin
        if (reset || softRst_r) begin
            openDrain_r <= `UPIO_ZERO_RESET;
        end else if (wrStrobe && addr_r == `UPIO_OD_EN) begin
            openDrain_r <= openDrain_r | wrBits;
        end else if (wrStrobe && addr_r == `UPIO_OD_DIS) begin
            openDrain_r <= openDrain_r & ~wrBits;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data: registered at the address phase so it stands in data phase
    always_ff @(posedge clk) begin
        if (reset) begin
            hrdata <= '0;
        end else if (addrTake && !hwrite) begin
            hrdata <= '0; // Unmapped and write-only read zero
            case (haddr[`UPIO_ADDR_MSB:0])
                `UPIO_PSEL_STAT: hrdata[`UPIO_FIELD_LSB +: 3] <= pinSel_r;
                `UPIO_DIR_STAT: hrdata[`UPIO_FIELD_LSB +: 3] <= dirOut_r;
                `UPIO_LVL_STAT: hrdata[`UPIO_FIELD_LSB +: 3] <= outLevel_r;
                `UPIO_PIN_STAT: hrdata[`UPIO_FIELD_LSB +: 3] <= pinLevel;
                `UPIO_OD_STAT: hrdata[`UPIO_FIELD_LSB +: 3] <= openDrain_r;
                default: hrdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin cells; serial function gets the pin when not under I/O control
    upio_pins_t funcOut;
    upio_pins_t funcOe;
    assign funcOut = '{rxd: 1'b0, txd: funcIn.txdOut, sck: funcIn.sckOut};
    assign funcOe = '{rxd: 1'b0, txd: 1'b1, sck: funcIn.sckOe};
    for (genvar i = 0; i < 3; i++) begin : g_pin
        upio_pin_cell u_cell (
            .clk(clk),
            .reset(reset),
            .gpioSel(pinSel_r[i]),
            .dirOut(dirOut_r[i]),
            .outLevel(outLevel_r[i]),
            .openDrain(openDrain_r[i]),
            .funcOut(funcOut[i]),
            .funcOe(funcOe[i]),
            .padIn(padIn[i]),
            .padOut(padOut[i]),
            .padOe(padOe[i]),
            .pinLevel(pinLevel[i])
        );
    end

    // Function receives sampled pin, idle high while pin is taken by I/O
    always_ff @(posedge clk) begin
        if (reset) begin
            funcRxd <= 3'b111;
        end else begin
            funcRxd <= padIn | pinSel_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks: all on the bus clock, quiet while reset is high
    // A write data phase aimed at one offset
    sequence s_wr(logic [`UPIO_ADDR_MSB:0] a);
        wrStrobe && addr_r == a;
    endsequence
    // A read address phase aimed at one offset
    sequence s_rd(logic [`UPIO_ADDR_MSB:0] a);
        addrTake && !hwrite && haddr[`UPIO_ADDR_MSB:0] == a;
    endsequence
    // First step of a soft reset: control write with the reset bit up
    sequence s_soft_req;
        s_wr(`UPIO_CTRL) ##0 hwdata[`UPIO_SOFT_RST_BIT];
    endsequence
    // Later steps: internal pulse, then the pulse on the port
    sequence s_soft_pulse;
        softRst_r ##1 portSoftReset;
    endsequence

    // Enable write hands pins to I/O
    a_psel_set: assert property (@(posedge clk) disable iff (reset)
        s_wr(`UPIO_PSEL_EN) && !softRst_r |=> (pinSel_r & $past(wrBits)) == $past(wrBits))
        else $error("pin select set failed");
    // Disable write gives pins back to the function
    a_psel_clr: assert property (@(posedge clk) disable iff (reset)
        s_wr(`UPIO_PSEL_DIS) && !softRst_r |=> (pinSel_r & $past(wrBits)) == `UPIO_ZERO_RESET)
        else $error("pin select clear failed");
    // Output enable write sets direction bits
    a_dir_set: assert property (@(posedge clk) disable iff (reset)
        s_wr(`UPIO_OUT_EN) && !softRst_r |=> (dirOut_r & $past(wrBits)) == $past(wrBits))
        else $error("direction set failed");
    // Output disable write clears direction bits
    a_dir_clr: assert property (@(posedge clk) disable iff (reset)
        s_wr(`UPIO_OUT_DIS) && !softRst_r |=> (dirOut_r & $past(wrBits)) == `UPIO_ZERO_RESET)
        else $error("direction clear failed");
    // Level set write raises programmed levels
    a_lvl_set: assert property (@(posedge clk) disable iff (reset)
        s_wr(`UPIO_LVL_SET) && !softRst_r |=> (outLevel_r & $past(wrBits)) == $past(wrBits))
        else $error("level set failed");
    // Level clear write lowers programmed levels
    a_lvl_clr: assert property (@(posedge clk) disable iff (reset)
        s_wr(`UPIO_LVL_CLR) && !softRst_r |=> (outLevel_r & $past(wrBits)) == `UPIO_ZERO_RESET)
        else $error("level clear failed");
    // Open drain enable write sets the mode
    a_od_set: assert property (@(posedge clk) disable iff (reset)
        s_wr(`UPIO_OD_EN) && !softRst_r |=> (openDrain_r & $past(wrBits)) == $past(wrBits))
        else $error("open drain set failed");
    // Open drain disable write restores normal drive
    a_od_clr: assert property (@(posedge clk) disable iff (reset)
        s_wr(`UPIO_OD_DIS) && !softRst_r |=> (openDrain_r & $past(wrBits)) == `UPIO_ZERO_RESET)
        else $error("open drain clear failed");

    // Bits written as zero never move, whatever the target
    a_zero_keep: assert property (@(posedge clk) disable iff (reset)
        wrStrobe && !softRst_r |=> ((pinSel_r ^ $past(pinSel_r)) & ~$past(wrBits)) == `UPIO_ZERO_RESET
        && ((dirOut_r ^ $past(dirOut_r)) & ~$past(wrBits)) == `UPIO_ZERO_RESET
        && ((outLevel_r ^ $past(outLevel_r)) & ~$past(wrBits)) == `UPIO_ZERO_RESET
        && ((openDrain_r ^ $past(openDrain_r)) & ~$past(wrBits)) == `UPIO_ZERO_RESET)
        else $error("zero bit changed a register");
    // Without a write nothing drifts
    a_regs_hold: assert property (@(posedge clk) disable iff (reset)
        !wrStrobe && !softRst_r |=> $stable(pinSel_r) && $stable(dirOut_r)
        && $stable(outLevel_r) && $stable(openDrain_r))
        else $error("register changed without a write");

    // Soft reset pulse restores every pin register
    a_soft_rst: assert property (@(posedge clk) disable iff (reset)
        softRst_r |=> pinSel_r == `UPIO_PSEL_RESET && dirOut_r == `UPIO_ZERO_RESET
        && outLevel_r == `UPIO_ZERO_RESET && openDrain_r == `UPIO_ZERO_RESET)
        else $error("soft reset did not restore");
    // Control write leads to both pulses in turn
    a_soft_seq: assert property (@(posedge clk) disable iff (reset)
        s_soft_req |=> s_soft_pulse)
        else $error("soft reset pulse missing");
    // Port pulse only ever follows the internal one
    a_soft_port: assert property (@(posedge clk) disable iff (reset)
        portSoftReset |-> $past(softRst_r))
        else $error("stray soft reset pulse");

    // Pin select status read back
    a_psel_read: assert property (@(posedge clk) disable iff (reset)
        s_rd(`UPIO_PSEL_STAT) |=> hrdata[`UPIO_FIELD_LSB +: 3] == $past(pinSel_r))
        else $error("pin select status read wrong");
    // Direction status read back
    a_dir_read: assert property (@(posedge clk) disable iff (reset)
        s_rd(`UPIO_DIR_STAT) |=> hrdata[`UPIO_FIELD_LSB +: 3] == $past(dirOut_r))
        else $error("direction status read wrong");
    // Programmed level status read back
    a_lvl_read: assert property (@(posedge clk) disable iff (reset)
        s_rd(`UPIO_LVL_STAT) |=> hrdata[`UPIO_FIELD_LSB +: 3] == $past(outLevel_r))
        else $error("level status read wrong");
    // Sampled pin level read back
    a_pin_read: assert property (@(posedge clk) disable iff (reset)
        s_rd(`UPIO_PIN_STAT) |=> hrdata[`UPIO_FIELD_LSB +: 3] == $past(pinLevel))
        else $error("pin level status read wrong");
    // Open drain status read back
    a_od_read: assert property (@(posedge clk) disable iff (reset)
        s_rd(`UPIO_OD_STAT) |=> hrdata[`UPIO_FIELD_LSB +: 3] == $past(openDrain_r))
        else $error("open drain status read wrong");
    // Bits outside the pin field always read zero
    a_rsvd_read: assert property (@(posedge clk) disable iff (reset)
        addrTake && !hwrite |=> (hrdata & ~`UPIO_FIELD_MASK) == 32'h0000_0000)
        else $error("reserved bits read nonzero");
    // Write-only pin select enable offset reads as zero
    a_wo_read: assert property (@(posedge clk) disable iff (reset)
        s_rd(`UPIO_PSEL_EN) |=> hrdata == 32'h0000_0000)
        else $error("write-only register read nonzero");

    // Transmit pin follows the serial function when released
    a_func_route: assert property (@(posedge clk) disable iff (reset)
        !pinSel_r.txd |=> padOut.txd == $past(funcIn.txdOut) && padOe.txd)
        else $error("transmit not routed to function");
    // Clock pin follows the serial function when released
    a_sck_route: assert property (@(posedge clk) disable iff (reset)
        !pinSel_r.sck |=> padOut.sck == $past(funcIn.sckOut) && padOe.sck == $past(funcIn.sckOe))
        else $error("clock not routed to function");
    // Receive pin is never driven by the function
    a_rxd_input: assert property (@(posedge clk) disable iff (reset)
        !pinSel_r.rxd |=> !padOe.rxd)
        else $error("receive pin driven by function");
    // Function sees idle high on pins taken by I/O
    a_func_rxd: assert property (@(posedge clk) disable iff (reset)
        pinSel_r != `UPIO_ZERO_RESET |=> (funcRxd & $past(pinSel_r)) == $past(pinSel_r))
        else $error("function saw a taken pin low");
    // Normal drive follows direction and level
    a_gpio_drive: assert property (@(posedge clk) disable iff (reset)
        pinSel_r.txd && !openDrain_r.txd |=> padOe.txd == $past(dirOut_r.txd)
        && padOut.txd == $past(outLevel_r.txd))
        else $error("normal drive wrong");
    // Open drain never drives a one
    a_od_drive: assert property (@(posedge clk) disable iff (reset)
        pinSel_r.sck && openDrain_r.sck |=> !padOut.sck)
        else $error("open drain drove high");
    // Open drain releases the line for a one
    a_od_release: assert property (@(posedge clk) disable iff (reset)
        pinSel_r.txd && openDrain_r.txd && outLevel_r.txd |=> !padOe.txd)
        else $error("open drain did not release");
endmodule
`default_nettype wire

// *** rtl/upio_pkg.sv ***
// Types shared by the serial port pin I/O controller
// Assumes no other package
package upio_pkg;
    // One bit per pin: clock, transmit, receive
    typedef struct packed {
        logic rxd;
        logic txd;
        logic sck;
    } upio_pins_t;
    // Serial function's drive on its transmit and clock pins
    typedef struct packed {
        logic txdOut;
        logic sckOut;
        logic sckOe;
    } upio_func_t;
    // Bus slave phase state
    typedef enum logic [0:0] {
        UPIO_IDLE = 1'b0,
        UPIO_DATA = 1'b1
    } upio_state_t;
endpackage

// *** rtl/upio_regs.svh ***
// Register map constants for the serial port pin I/O controller
// Assumes inclusion by bare name from the rtl folder
`ifndef UPIO_REGS_SVH
`define UPIO_REGS_SVH
`define UPIO_PSEL_EN 12'h000
`define UPIO_PSEL_DIS 12'h004
`define UPIO_PSEL_STAT 12'h008
`define UPIO_OUT_EN 12'h010
`define UPIO_OUT_DIS 12'h014
`define UPIO_DIR_STAT 12'h018
`define UPIO_LVL_SET 12'h030
`define UPIO_LVL_CLR 12'h034
`define UPIO_LVL_STAT 12'h038
`define UPIO_PIN_STAT 12'h03C
`define UPIO_OD_EN 12'h040
`define UPIO_OD_DIS 12'h044
`define UPIO_OD_STAT 12'h048
`define UPIO_CTRL 12'h060
`define UPIO_FIELD_LSB 16
`define UPIO_FIELD_MASK 32'h0007_0000
`define UPIO_SOFT_RST_BIT 0
`define UPIO_PSEL_RESET 3'h7
`define UPIO_ZERO_RESET 3'h0
`define UPIO_ADDR_MSB 11
`endif

// *** test/upio_pin_partner.sv ***
// Far-side model of the three serial port pins
// Assumes registered pad outputs from the pin controller, pull-ups on all pins
`timescale 1ns/1ps
`default_nettype none
module upio_pin_partner import upio_pkg::*; (
    input wire upio_pins_t padOut,
    input wire upio_pins_t padOe,
    input wire upio_pins_t extDrive,
    input wire upio_pins_t extLevel,
    output upio_pins_t padIn
);
    ////////////////////////////////////////////////////////////////////////
    // Wire level: controller drive wins, else far side, else pull-up
    // Released lines float high so a stale level never survives
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            padIn[i] = padOe[i] ? padOut[i] : (extDrive[i] ? extLevel[i] : 1'b1);
        end
    end
endmodule
`default_nettype wire

// *** test/usart_pin_io_control_bench.sv ***
// Self-checking bench for the serial port pin controller
// Assumes rtl package and register header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "upio_regs.svh"
module usart_pin_io_control_bench import upio_pkg::*;;
    logic clk = 1'b0; // Bus clock
    logic reset = 1'b1; // Sync reset
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2; // Whole words only
    logic [31:0] hrdata;
    logic hreadyout, hresp, portSoftReset;
    upio_func_t funcIn = '0; // Serial function drives
    upio_pins_t funcRxd, padIn, padOut, padOe;
    upio_pins_t extDrive = '0; // Far side drive enables
    upio_pins_t extLevel = '0;
    int num_errors = 0;
    int cmp_count = 0;
    logic [2:0] sel = 3'h7; // Expected register images
    logic [2:0] dir = 3'h0;
    logic [2:0] lvl = 3'h0;
    logic [2:0] od = 3'h0;
    logic [11:0] wrAddr [8] = '{`UPIO_PSEL_EN, `UPIO_PSEL_DIS, `UPIO_OUT_EN, `UPIO_OUT_DIS,
        `UPIO_LVL_SET, `UPIO_LVL_CLR, `UPIO_OD_EN, `UPIO_OD_DIS};

    upio_pin_ctrl i_dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .funcIn(funcIn), .funcRxd(funcRxd), .padIn(padIn),
        .padOut(padOut), .padOe(padOe), .portSoftReset(portSoftReset));
    upio_pin_partner i_pins (.padOut(padOut), .padOe(padOe), .extDrive(extDrive), .extLevel(extLevel),
        .padIn(padIn));

    ////////////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bounded wait for ready at a rising edge
    task automatic waitReady();
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (hreadyout === 1'b1) break;
        end
        if (n >= 50) begin
            num_errors++; // Hung bus counts as a mismatch
            give_verdict();
        end
    endtask

    // One single word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0_0000, a};
        waitReady();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        waitReady();
        q = hrdata;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Set or clear by ones, odd table entries clear
    function automatic logic [2:0] upd(input logic [2:0] r, input int k, input logic [31:0] d);
        return k[0] ? (r & ~d[18:16]) : (r | d[18:16]);
    endfunction

    // Expected {enable, level} of one pad
    function automatic logic [1:0] expPad(input int i);
        if (sel[i]) return od[i] ? {dir[i] & ~lvl[i], 1'b0} : {dir[i], lvl[i]};
        case (i)
            0: return {funcIn.sckOe, funcIn.sckOut};
            1: return {1'b1, funcIn.txdOut};
            default: return 2'h0;
        endcase
    endfunction

    // Expected wire level with pull-up
    function automatic logic wireLvl(input int i);
        logic [1:0] e;
        e = expPad(i);
        return e[1] ? e[0] : (extDrive[i] ? extLevel[i] : 1'b1);
    endfunction

    // Status registers against the images
    task automatic checkRegs();
        logic [31:0] q;
        bus(1'b0, `UPIO_PSEL_STAT, 32'h0, q);
        chk(q, {13'h0, sel, 16'h0});
        bus(1'b0, `UPIO_DIR_STAT, 32'h0, q);
        chk(q, {13'h0, dir, 16'h0});
        bus(1'b0, `UPIO_LVL_STAT, 32'h0, q);
        chk(q, {13'h0, lvl, 16'h0});
        bus(1'b0, `UPIO_OD_STAT, 32'h0, q);
        chk(q, {13'h0, od, 16'h0});
        chk(32'(hresp), 32'h0);
    endtask

    // Pads, function view and sampled pin levels
    task automatic checkPins();
        logic [31:0] q;
        logic [1:0] e;
        logic [2:0] pv;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            e = expPad(i);
            pv[i] = wireLvl(i);
            chk(32'(padOe[i]), 32'(e[1]));
            if (e[1]) chk(32'(padOut[i]), 32'(e[0]));
            chk(32'(funcRxd[i]), 32'(sel[i] | pv[i]));
        end
        bus(1'b0, `UPIO_PIN_STAT, 32'h0, q);
        chk(q, {13'h0, pv, 16'h0});
        chk(32'(portSoftReset), 32'h0);
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the expected run of about 660 cycles
    initial begin
        #(100 * 20000);
        num_errors++;
        give_verdict();
    end

    // Main sequence
    initial begin
        logic [31:0] q, d;
        int k;
        q = $urandom(32'h0000_9d03);
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        checkRegs(); // Reset values
        bus(1'b0, 12'h00C, 32'h0, q);
        chk(q, 32'h0000_0000);
        bus(1'b0, `UPIO_PSEL_EN, 32'h0, q);
        chk(q, 32'h0000_0000);
        // Hand all pins to the serial function, all bits set
        bus(1'b1, `UPIO_PSEL_DIS, 32'hFFFF_FFFF, q);
        sel = 3'h0;
        checkRegs();
        checkPins();
        // Random writes across all eight write-only registers
        for (int n = 0; n < 40; n++) begin
            k = $urandom_range(7);
            d = $urandom();
            funcIn <= upio_func_t'(3'($urandom_range(7)));
            extDrive <= upio_pins_t'(3'($urandom_range(7)));
            extLevel <= upio_pins_t'(3'($urandom_range(7)));
            bus(1'b1, wrAddr[k], d, q);
            case (k / 2)
                0: sel = upd(sel, k, d);
                1: dir = upd(dir, k, d);
                2: lvl = upd(lvl, k, d);
                default: od = upd(od, k, d);
            endcase
            checkRegs();
            checkPins();
        end
        // Load every field, then soft reset restores reset values
        for (int n = 2; n < 8; n += 2) begin
            bus(1'b1, wrAddr[n], 32'h0007_0000, q);
        end
        bus(1'b1, `UPIO_PSEL_DIS, 32'h0007_0000, q);
        bus(1'b1, `UPIO_CTRL, 32'h0000_0001, q);
        {sel, dir, lvl, od} = {3'h7, 9'h000};
        // Port pulse stands for exactly the second cycle after the write
        @(negedge clk);
        chk(32'(portSoftReset), 32'h0);
        @(negedge clk);
        chk(32'(portSoftReset), 32'h1);
        @(negedge clk);
        chk(32'(portSoftReset), 32'h0);
        @(posedge clk);
        checkRegs();
        checkPins();
        give_verdict();
    end
endmodule
`default_nettype wire
